/* pqa_mod_model.sv */
// Purpose: behavioural module on one downstream bus
// Assumes: open-drain wires with pull-ups; answers only at A0 or A2
// Notes: read data is 5A; optional clock stretch after each ack
module pqa_mod_model #(parameter int STRETCH = 0) (
    // wire levels
    input wire logic scl,
    input wire logic sda,
    // pull-downs
    output logic scl_oe,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] RDATA = 8'h5A;
    int bitn = 0;
    logic [7:0] sh = '0;
    logic rd = 0, first = 0;
    initial scl_oe = 0;
    initial sda_oe = 0;
    always @(negedge sda) if (scl) begin
        bitn = 0;
        first = 1;
        rd = 0;
    end
    always @(posedge scl) begin
        // a master nack on the ninth clock ends the read
        if (bitn == 8 && sda) rd = 0;
        sh = {sh[6:0], sda};
        bitn++;
    end
    always @(negedge scl) begin
        if (bitn == 9) bitn = 0;
        if (bitn == 8) begin
            sda_oe = first ? sh[7:2] == 6'h28 : !rd;
            if (first) rd = sh[0] & sda_oe;
            first = 0;
        end else sda_oe = rd & !RDATA[7 - bitn];
        if (STRETCH > 0 && bitn == 0) begin
            scl_oe = 1;
            #(STRETCH) scl_oe = 0;
        end
    end
endmodule

/* pqa_pkg.sv */
// Purpose: shared constants and types of the port i2c arbiter
// Assumes: 25 MHz system clock
// Notes: counts derive from the printed times and rates
package pqa_pkg;
    localparam int NPORT = 4;
    localparam int CLK_HZ = 25_000_000;
    localparam int SCL_MIN_HZ = 100_000;
    localparam int SCL_MAX_HZ = 400_000;
    // quarter periods of the downstream clock, in system clocks
    localparam logic [6:0] QDIV_SLOW = 7'(CLK_HZ / (4 * SCL_MIN_HZ));
    localparam logic [6:0] QDIV_FAST = 7'((CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ));
    localparam int INT_LAT_US = 50;
    localparam int INT_LAT_CYC = INT_LAT_US * (CLK_HZ / 1_000_000);
    localparam int SCL_STUCK_MS = 35;
    localparam int SCL_STUCK_CYC = SCL_STUCK_MS * (CLK_HZ / 1000);
    localparam logic [7:0] DEV0_RST = 8'hA0;
    localparam logic [7:0] DEV1_RST = 8'hA2;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] STEP_ADDR = 2'h0;
    localparam logic [1:0] STEP_OFF = 2'h1;
    localparam logic [1:0] STEP_DATA = 2'h2;
    localparam logic [1:0] STEP_RDATA = 2'h3;
    typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} pqa_eng_e;
    typedef enum logic [2:0] {O_NONE, O_REM, O_IP, O_SW, O_PF} pqa_own_e;
endpackage

/* pqa_port_arbiter.sv */
// Purpose: four downstream i2c masters with per-port access arbitration
// Assumes: host side already decoded into request ports
// Notes: each arbitrated unit is one byte transaction
module pqa_port_arbiter
    import pqa_pkg::*;
#(
    parameter int SCL_STUCK_DEF = SCL_STUCK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // downstream buses, open drain
    input wire logic [NPORT-1:0] scl_i,
    output logic [NPORT-1:0] scl_o_q,
    output logic [NPORT-1:0] scl_oe_q,
    input wire logic [NPORT-1:0] sda_i,
    output logic [NPORT-1:0] sda_o_q,
    output logic [NPORT-1:0] sda_oe_q,
    // status pins and port configuration
    input wire logic [NPORT-1:0][2:0] stat_pin,
    input wire logic [NPORT-1:0][2:0] rise_en,
    input wire logic [NPORT-1:0][2:0] fall_en,
    input wire logic [NPORT-1:0] int_clr,
    input wire logic [NPORT-1:0] port_rst,
    input wire logic [NPORT-1:0][19:0] stuck_lim,
    input wire logic [NPORT-1:0][6:0] qdiv,
    // host interrupt and flags
    output logic host_int_o_q,
    output logic host_int_oe_q,
    output logic [NPORT-1:0] int_flag_q,
    output logic [NPORT-1:0] scl_stuck_q,
    // address map
    input wire logic map_we,
    input wire logic map_sel,
    input wire logic [7:0] map_addr,
    // remote access
    input wire logic rem_req,
    input wire logic [1:0] rem_port,
    input wire logic rem_dsel,
    input wire logic rem_rw,
    input wire logic [7:0] rem_off,
    input wire logic [7:0] rem_wdata,
    output logic [NPORT-1:0] rem_pend_q,
    // interrupt-driven prefetch
    input wire logic [NPORT-1:0] ip_req,
    input wire logic [NPORT-1:0] ip_dsel,
    input wire logic [NPORT-1:0][7:0] ip_off,
    input wire logic [NPORT-1:0][4:0] ip_len,
    // scheduled write
    input wire logic [NPORT-1:0] sw_req,
    input wire logic [NPORT-1:0] sw_dsel,
    input wire logic [NPORT-1:0][7:0] sw_off,
    input wire logic [NPORT-1:0][7:0] sw_data,
    // periodic prefetch
    input wire logic [NPORT-1:0] pf_start,
    input wire logic [NPORT-1:0] pf_stop,
    input wire logic [NPORT-1:0] pf_due,
    input wire logic [NPORT-1:0] pf_dsel,
    input wire logic [NPORT-1:0][7:0] pf_off,
    input wire logic [NPORT-1:0][4:0] pf_len,
    // transfer results
    output logic [NPORT-1:0] xfer_done_q,
    output logic [NPORT-1:0] xfer_nack_q,
    output pqa_own_e xfer_src_q [NPORT],
    output logic [NPORT-1:0][7:0] xfer_off_q,
    output logic [NPORT-1:0][7:0] xfer_data_q
);
    function automatic logic [6:0] eff_div(input logic [6:0] v);
        if (v < QDIV_FAST) return QDIV_FAST;
        if (v > QDIV_SLOW) return QDIV_SLOW;
        return v;
    endfunction

    logic [NPORT-1:0] scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    logic [NPORT-1:0][2:0] pin_m_q, pin_s_q, pin_p_q, pin_ev;
    logic [2:0] arm_q;
    logic [NPORT-1:0] ev_flag_q, ev_flag_d, stuck_d, agg_d, ip_ok, tick;
    logic [NPORT-1:0][19:0] stk_q, stk_d, stk_lim;
    logic host_int_oe_d;
    pqa_eng_e st_q [NPORT], st_d [NPORT];
    pqa_own_e own_q [NPORT], own_d [NPORT], src_d [NPORT];
    logic [NPORT-1:0][1:0] qtr_q, qtr_d, step_q, step_d;
    logic [NPORT-1:0][6:0] tc_q, tc_d;
    logic [NPORT-1:0][3:0] bit_q, bit_d;
    logic [NPORT-1:0][7:0] sh_q, sh_d, rd_q, rd_d, dev_q, dev_d, off_q, off_d, wd_q, wd_d;
    logic [NPORT-1:0][7:0] rdev_q, rdev_d, rofs_q, rofs_d, rwd_q, rwd_d, doff_d, ddat_d;
    logic [NPORT-1:0] nack_q, nack_d, rw_q, rw_d, rrw_q, rrw_d, scl_oe_d, sda_oe_d;
    logic [NPORT-1:0] rem_pend_d, ip_pend_q, ip_pend_d, sw_pend_q, sw_pend_d;
    logic [NPORT-1:0] pf_en_q, pf_en_d, pf_run_q, pf_run_d, done_d, dnack_d;
    logic [NPORT-1:0][4:0] ip_idx_q, ip_idx_d, pf_idx_q, pf_idx_d;
    logic [7:0] map_q [2], map_d [2];

    // two-stage synchronisers for all pins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scl_m_q <= '1;
            scl_s_q <= '1;
            sda_m_q <= '1;
            sda_s_q <= '1;
            pin_m_q <= '0;
            pin_s_q <= '0;
            pin_p_q <= '0;
            arm_q <= '0;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            pin_m_q <= stat_pin;
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
            arm_q <= {arm_q[1:0], 1'b1};
        end
    end

    // event flags, stuck timers and the shared interrupt
    always_comb begin
        ev_flag_d = ev_flag_q;
        stuck_d = scl_stuck_q;
        stk_d = stk_q;
        for (int p = 0; p < NPORT; p++) begin
            stk_lim[p] = (stuck_lim[p] == 20'h00000) ? 20'(SCL_STUCK_DEF) : stuck_lim[p];
            // no edges until the pipe holds real pin levels, so high idle pins stay quiet
            pin_ev[p] = {3{arm_q[2]}} & ((pin_s_q[p] & ~pin_p_q[p] & rise_en[p])
                      | (~pin_s_q[p] & pin_p_q[p] & fall_en[p]));
            if (scl_s_q[p]) stk_d[p] = 20'h00000;
            else if (stk_q[p] != stk_lim[p]) stk_d[p] = stk_q[p] + 20'h00001;
            if (port_rst[p]) stuck_d[p] = 1'b0;
            if (!scl_s_q[p] && stk_q[p] == stk_lim[p]) stuck_d[p] = 1'b1;
            if (int_clr[p]) ev_flag_d[p] = 1'b0;
            // a new event wins over a clear in the same cycle
            if (|pin_ev[p] || ip_ok[p]) ev_flag_d[p] = 1'b1;
            agg_d[p] = ev_flag_d[p] | stuck_d[p];
        end
        host_int_oe_d = |int_flag_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ev_flag_q <= '0;
            scl_stuck_q <= '0;
            stk_q <= '0;
            int_flag_q <= '0;
            host_int_oe_q <= 1'b0;
            host_int_o_q <= 1'b0;
            scl_o_q <= '0;
            sda_o_q <= '0;
        end else begin
            ev_flag_q <= ev_flag_d;
            scl_stuck_q <= stuck_d;
            stk_q <= stk_d;
            int_flag_q <= agg_d;
            host_int_oe_q <= host_int_oe_d;
            host_int_o_q <= 1'b0;
            scl_o_q <= '0;
            sda_o_q <= '0;
        end
    end

    // byte engines and per-port arbitration
    always_comb begin
        st_d = st_q; own_d = own_q; qtr_d = qtr_q; tc_d = tc_q; bit_d = bit_q;
        step_d = step_q; sh_d = sh_q; rd_d = rd_q; nack_d = nack_q; dev_d = dev_q;
        rw_d = rw_q; off_d = off_q; wd_d = wd_q; scl_oe_d = scl_oe_q; sda_oe_d = sda_oe_q;
        rem_pend_d = rem_pend_q; rdev_d = rdev_q; rrw_d = rrw_q; rofs_d = rofs_q;
        rwd_d = rwd_q; ip_pend_d = ip_pend_q; ip_idx_d = ip_idx_q; sw_pend_d = sw_pend_q;
        pf_en_d = pf_en_q; pf_run_d = pf_run_q; pf_idx_d = pf_idx_q;
        done_d = '0; dnack_d = xfer_nack_q; src_d = xfer_src_q; doff_d = xfer_off_q;
        ddat_d = xfer_data_q; ip_ok = '0; map_d = map_q;
        if (map_we) map_d[map_sel] = map_addr;
        for (int p = 0; p < NPORT; p++) begin
            // at or above, so a divider lowered mid-transfer cannot let the count wrap
            tick[p] = tc_q[p] >= eff_div(qdiv[p]) - 7'h01;
            tc_d[p] = (st_q[p] == E_IDLE || tick[p]) ? 7'h00 : tc_q[p] + 7'h01;
            unique case (st_q[p])
                E_IDLE: begin
                    qtr_d[p] = 2'h0;
                    step_d[p] = STEP_ADDR;
                    nack_d[p] = 1'b0;
                    // grants only at byte boundaries, one source at a time
                    if (ip_pend_q[p] && ip_idx_q[p] != 5'h00) own_d[p] = O_IP;
                    else if (rem_pend_q[p]) own_d[p] = O_REM;
                    else if (ip_pend_q[p]) own_d[p] = O_IP;
                    else if (sw_pend_q[p]) own_d[p] = O_SW;
                    else if (pf_run_q[p]) own_d[p] = O_PF;
                    else own_d[p] = O_NONE;
                    if (own_d[p] != O_PF) pf_idx_d[p] = 5'h00;
                    if (own_d[p] == O_REM) begin
                        dev_d[p] = rdev_q[p];
                        rw_d[p] = rrw_q[p];
                        off_d[p] = rofs_q[p];
                        wd_d[p] = rwd_q[p];
                    end else if (own_d[p] == O_IP) begin
                        dev_d[p] = map_q[ip_dsel[p]];
                        rw_d[p] = 1'b1;
                        off_d[p] = ip_off[p] + {3'h0, ip_idx_q[p]};
                    end else if (own_d[p] == O_SW) begin
                        dev_d[p] = map_q[sw_dsel[p]];
                        rw_d[p] = 1'b0;
                        off_d[p] = sw_off[p];
                        wd_d[p] = sw_data[p];
                    end else begin
                        dev_d[p] = map_q[pf_dsel[p]];
                        rw_d[p] = 1'b1;
                        off_d[p] = pf_off[p] + {3'h0, pf_idx_q[p]};
                    end
                    if (own_d[p] != O_NONE) st_d[p] = E_START;
                end
                E_START: if (tick[p]) begin
                    unique case (qtr_q[p])
                        2'h0: begin sda_oe_d[p] = 1'b0; qtr_d[p] = 2'h1; end
                        2'h1: begin scl_oe_d[p] = 1'b0; qtr_d[p] = 2'h2; end
                        2'h2: if (scl_s_q[p]) begin
                            sda_oe_d[p] = 1'b1;
                            qtr_d[p] = 2'h3;
                        end
                        2'h3: begin
                            scl_oe_d[p] = 1'b1;
                            qtr_d[p] = 2'h0;
                            bit_d[p] = 4'h0;
                            sh_d[p] = {dev_q[p][7:1], step_q[p] != STEP_ADDR};
                            st_d[p] = E_BIT;
                        end
                    endcase
                end
                E_BIT: if (tick[p]) begin
                    unique case (qtr_q[p])
                        2'h0: begin
                            sda_oe_d[p] = (bit_q[p] == ACK_BIT || step_q[p] == STEP_RDATA)
                                        ? 1'b0 : ~sh_q[p][7];
                            qtr_d[p] = 2'h1;
                        end
                        2'h1: begin scl_oe_d[p] = 1'b0; qtr_d[p] = 2'h2; end
                        2'h2: if (scl_s_q[p]) begin
                            if (bit_q[p] != ACK_BIT && step_q[p] == STEP_RDATA)
                                rd_d[p] = {rd_q[p][6:0], sda_s_q[p]};
                            if (bit_q[p] == ACK_BIT && step_q[p] != STEP_RDATA)
                                nack_d[p] = sda_s_q[p];
                            qtr_d[p] = 2'h3;
                        end
                        2'h3: begin
                            scl_oe_d[p] = 1'b1;
                            qtr_d[p] = 2'h0;
                            if (bit_q[p] != ACK_BIT) begin
                                bit_d[p] = bit_q[p] + 4'h1;
                                sh_d[p] = {sh_q[p][6:0], 1'b0};
                            end else if (nack_q[p] || step_q[p] == STEP_RDATA
                                         || (step_q[p] == STEP_DATA && !rw_q[p])) begin
                                st_d[p] = E_STOP;
                            end else if (step_q[p] == STEP_OFF && rw_q[p]) begin
                                step_d[p] = STEP_DATA;
                                st_d[p] = E_START;
                            end else begin
                                step_d[p] = step_q[p] + 2'h1;
                                bit_d[p] = 4'h0;
                                sh_d[p] = (step_q[p] == STEP_ADDR) ? off_q[p] : wd_q[p];
                            end
                        end
                    endcase
                end
                E_STOP: if (tick[p]) begin
                    unique case (qtr_q[p])
                        2'h0: begin sda_oe_d[p] = 1'b1; qtr_d[p] = 2'h1; end
                        2'h1: begin scl_oe_d[p] = 1'b0; qtr_d[p] = 2'h2; end
                        2'h2: if (scl_s_q[p]) qtr_d[p] = 2'h3;
                        2'h3: begin
                            sda_oe_d[p] = 1'b0;
                            st_d[p] = E_IDLE;
                            done_d[p] = 1'b1;
                            dnack_d[p] = nack_q[p];
                            src_d[p] = own_q[p];
                            doff_d[p] = off_q[p];
                            ddat_d[p] = rd_q[p];
                            unique case (own_q[p])
                                O_REM: rem_pend_d[p] = 1'b0;
                                O_SW: sw_pend_d[p] = 1'b0;
                                O_IP: if (nack_q[p] || ip_idx_q[p] == ip_len[p]) begin
                                    ip_pend_d[p] = 1'b0;
                                    ip_idx_d[p] = 5'h00;
                                    ip_ok[p] = !nack_q[p];
                                end else begin
                                    ip_idx_d[p] = ip_idx_q[p] + 5'h01;
                                end
                                O_PF: if (nack_q[p] || pf_idx_q[p] == pf_len[p]) begin
                                    pf_run_d[p] = 1'b0;
                                    pf_idx_d[p] = 5'h00;
                                end else begin
                                    pf_idx_d[p] = pf_idx_q[p] + 5'h01;
                                end
                                default: ;
                            endcase
                        end
                    endcase
                end
            endcase
            // requests queue here and wait for the engine to go idle
            if (rem_req && rem_port == 2'(p) && !rem_pend_q[p]) begin
                rem_pend_d[p] = 1'b1;
                rdev_d[p] = map_q[rem_dsel];
                rrw_d[p] = rem_rw;
                rofs_d[p] = rem_off;
                rwd_d[p] = rem_wdata;
            end
            if (ip_req[p]) ip_pend_d[p] = 1'b1;
            if (sw_req[p]) sw_pend_d[p] = 1'b1;
            if (pf_start[p]) pf_en_d[p] = 1'b1;
            if (pf_due[p] && pf_en_q[p]) pf_run_d[p] = 1'b1;
            if (pf_stop[p] || port_rst[p]) begin
                pf_en_d[p] = 1'b0;
                pf_run_d[p] = 1'b0;
            end
            if (port_rst[p]) begin
                st_d[p] = E_IDLE;
                own_d[p] = O_NONE;
                scl_oe_d[p] = 1'b0;
                sda_oe_d[p] = 1'b0;
                rem_pend_d[p] = 1'b0;
                ip_pend_d[p] = 1'b0;
                sw_pend_d[p] = 1'b0;
                ip_idx_d[p] = 5'h00;
                pf_idx_d[p] = 5'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= '{default: E_IDLE}; own_q <= '{default: O_NONE};
            xfer_src_q <= '{default: O_NONE}; qtr_q <= '0; tc_q <= '0; bit_q <= '0;
            step_q <= '0; sh_q <= '0; rd_q <= '0; nack_q <= '0; dev_q <= '0; rw_q <= '0;
            off_q <= '0; wd_q <= '0; scl_oe_q <= '0; sda_oe_q <= '0; rem_pend_q <= '0;
            rdev_q <= '0; rrw_q <= '0; rofs_q <= '0; rwd_q <= '0; ip_pend_q <= '0;
            ip_idx_q <= '0; sw_pend_q <= '0; pf_en_q <= '0; pf_run_q <= '0; pf_idx_q <= '0;
            xfer_done_q <= '0; xfer_nack_q <= '0; xfer_off_q <= '0; xfer_data_q <= '0;
            map_q[0] <= DEV0_RST;
            map_q[1] <= DEV1_RST;
        end else begin
            st_q <= st_d; own_q <= own_d; xfer_src_q <= src_d; qtr_q <= qtr_d; tc_q <= tc_d;
            bit_q <= bit_d; step_q <= step_d; sh_q <= sh_d; rd_q <= rd_d; nack_q <= nack_d;
            dev_q <= dev_d; rw_q <= rw_d; off_q <= off_d; wd_q <= wd_d; scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d; rem_pend_q <= rem_pend_d; rdev_q <= rdev_d; rrw_q <= rrw_d;
            rofs_q <= rofs_d; rwd_q <= rwd_d; ip_pend_q <= ip_pend_d; ip_idx_q <= ip_idx_d;
            sw_pend_q <= sw_pend_d; pf_en_q <= pf_en_d; pf_run_q <= pf_run_d;
            pf_idx_q <= pf_idx_d; xfer_done_q <= done_d; xfer_nack_q <= dnack_d;
            xfer_off_q <= doff_d; xfer_data_q <= ddat_d; map_q <= map_d;
        end
    end

    // a synced edge reaches the shared line in two edges, far inside INT_LAT_CYC
    localparam int LAT_CHK = 4;
    logic any_flag;
    assign any_flag = |int_flag_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_int_lat; (|pin_ev) |-> ##[1:LAT_CHK] host_int_oe_q; endproperty
    a_int_lat: assert property (p_int_lat) else $error("interrupt late");
    property p_wor; host_int_oe_q |-> !host_int_o_q && $past(any_flag); endproperty
    a_wor: assert property (p_wor) else $error("interrupt drives high");
    property p_int_lvl; 1'b1 |=> host_int_oe_q == $past(any_flag); endproperty
    a_int_lvl: assert property (p_int_lvl) else $error("interrupt level wrong");
    property p_map_rst; $rose(rst_b) |-> map_q[0] == DEV0_RST && map_q[1] == DEV1_RST;
    endproperty
    a_map_rst: assert property (p_map_rst) else $error("map reset wrong");
    property p_map_wr; map_we |=> map_q[$past(map_sel)] == $past(map_addr); endproperty
    a_map_wr: assert property (p_map_wr) else $error("map write lost");
    property p_decode;
        (rem_req && !rem_pend_q[rem_port] && !map_we)
            |=> rdev_q[$past(rem_port)] == map_q[$past(rem_dsel)];
    endproperty
    a_decode: assert property (p_decode) else $error("remote decode wrong");

    for (genvar g = 0; g < NPORT; g++) begin : g_chk
        logic idle, ip_mid;
        assign idle = st_q[g] == E_IDLE && !port_rst[g];
        assign ip_mid = ip_pend_q[g] && ip_idx_q[g] != 5'h00;
        property p_div; tc_q[g] < QDIV_SLOW; endproperty
        a_div: assert property (p_div) else $error("scl divider overrun");
        property p_stretch;
            (st_q[g] == E_BIT && qtr_q[g] == 2'h2 && !scl_s_q[g] && !port_rst[g])
                |=> qtr_q[g] == 2'h2 && !scl_oe_q[g];
        endproperty
        a_stretch: assert property (p_stretch) else $error("stretch ignored");
        property p_rem_first; (idle && rem_pend_q[g] && !ip_mid) |=> own_q[g] == O_REM;
        endproperty
        a_rem_first: assert property (p_rem_first) else $error("remote not first");
        property p_resume;
            (idle && pf_run_q[g] && !rem_pend_q[g] && !ip_pend_q[g] && !sw_pend_q[g]
             && !pf_stop[g]) |=> own_q[g] == O_PF;
        endproperty
        a_resume: assert property (p_resume) else $error("prefetch not resumed");
        property p_pf_restart; (idle && rem_pend_q[g]) |=> pf_idx_q[g] == 5'h00; endproperty
        a_pf_restart: assert property (p_pf_restart) else $error("prefetch index kept");
        property p_ip_hold; (idle && ip_mid) |=> own_q[g] == O_IP; endproperty
        a_ip_hold: assert property (p_ip_hold) else $error("prefetch preempted");
        property p_rem_hold;
            (own_q[g] == O_REM && st_q[g] != E_IDLE && !port_rst[g]) |=> own_q[g] == O_REM;
        endproperty
        a_rem_hold: assert property (p_rem_hold) else $error("remote preempted");
        property p_stuck;
            (!scl_s_q[g] && stk_q[g] == stk_lim[g] && !port_rst[g]) |=> scl_stuck_q[g];
        endproperty
        a_stuck: assert property (p_stuck) else $error("stuck flag missed");
        property p_owned; st_q[g] != E_IDLE |-> own_q[g] != O_NONE; endproperty
        a_owned: assert property (p_owned) else $error("bus without owner");
    end

    c_rem_done: cover property (xfer_done_q[0] && xfer_src_q[0] == O_REM);
    c_pf_preempt: cover property (st_q[0] == E_IDLE && pf_idx_q[0] != 5'h00 && rem_pend_q[0]);
    c_host_int: cover property ($rose(host_int_oe_q));
endmodule

/* test_pqa_port_arbiter.sv */
// Purpose: self-checking bench of the port arbiter
// Assumes: one module model per port, port 1 stretches the clock
// Notes: stuck limit shortened to 200 cycles
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_pqa_port_arbiter;
    import pqa_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_b = 0, map_we = 0, map_sel = 1, rem_req = 0, rem_dsel = 0, rem_rw = 1;
    logic [1:0] rem_port = 0;
    logic [7:0] map_addr = 8'hA4, rem_off = 8'h10, rem_wdata = 8'h33;
    logic [3:0] hold = '0, int_clr = '0, port_rst = '0, ip_req = '0, ip_dsel = '0, sw_req = '0;
    logic [3:0] sw_dsel = '0, pf_start = '0, pf_stop = '0, pf_due = '0, pf_dsel = '0;
    logic [3:0][2:0] stat_pin = '0, rise_en = {4{3'h1}}, fall_en = '0;
    logic [3:0][19:0] stuck_lim = '0;
    logic [3:0][6:0] qdiv = {{3{7'h10}}, 7'h3E};
    logic [3:0][7:0] ip_off = {4{8'h40}}, sw_off = {4{8'h60}}, sw_data = {4{8'h77}};
    logic [3:0][7:0] pf_off = {4{8'h20}}, xfer_off_q, xfer_data_q;
    logic [3:0][4:0] ip_len = {4{5'h02}}, pf_len = {4{5'h03}};
    logic [3:0] int_flag_q, scl_stuck_q, rem_pend_q, xfer_done_q, xfer_nack_q;
    logic host_int_o_q, host_int_oe_q;
    pqa_own_e xfer_src_q [NPORT];
    wire [3:0] scl_oe_q, sda_oe_q, m_scl, m_sda, scl_o_q, sda_o_q;
    wire [3:0] scl_w = ~(scl_oe_q | m_scl | hold);
    wire [3:0] sda_w = ~(sda_oe_q | m_sda);
    int err_total = 0, n_compared = 0;
    pqa_port_arbiter #(.SCL_STUCK_DEF(200)) dut (.clk, .rst_b, .scl_i(scl_w), .scl_o_q,
        .scl_oe_q, .sda_i(sda_w), .sda_o_q, .sda_oe_q, .stat_pin, .rise_en, .fall_en,
        .int_clr, .port_rst, .stuck_lim, .qdiv, .host_int_o_q, .host_int_oe_q, .int_flag_q,
        .scl_stuck_q, .map_we, .map_sel, .map_addr, .rem_req, .rem_port, .rem_dsel, .rem_rw,
        .rem_off, .rem_wdata, .rem_pend_q, .ip_req, .ip_dsel, .ip_off, .ip_len, .sw_req,
        .sw_dsel, .sw_off, .sw_data, .pf_start, .pf_stop, .pf_due, .pf_dsel, .pf_off,
        .pf_len, .xfer_done_q, .xfer_nack_q, .xfer_src_q, .xfer_off_q, .xfer_data_q);
    for (genvar g = 0; g < 4; g++) begin : g_mod
        pqa_mod_model #(.STRETCH(g == 1 ? 3000 : 0)) u_mod (.scl(scl_w[g]), .sda(sda_w[g]),
            .scl_oe(m_scl[g]), .sda_oe(m_sda[g]));
    end
    initial forever #20 clk = ~clk;
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // waits for the next finished byte on port p, then steps past it
    task automatic nxt(int p);
        int k;
        for (k = 0; xfer_done_q[p] !== 1'b1 && k < 20000; k++) step();
        if (k == 20000) begin
            err_total++;
            wrap_up();
        end
        step();
    endtask
    task automatic rem(int p, logic dsel);
        rem_port = 2'(p);
        rem_dsel = dsel;
        rem_req = 1;
        step();
        rem_req = 0;
    endtask
    initial begin
        int k;
        step(10);
        rst_b = 1;
        step();
        `CHK({host_int_oe_q, int_flag_q}, 5'h00)
        `CHK({scl_o_q, sda_o_q, host_int_o_q}, 9'h000)
        rem(0, 0);
        nxt(0);
        `CHK({xfer_src_q[0], xfer_nack_q[0], xfer_data_q[0]}, {O_REM, 9'h05A})
        map_we = 1;
        step();
        map_we = 0;
        rem(1, 1);
        nxt(1);
        `CHK(xfer_nack_q[1], 1'b1)
        stat_pin[2] = 3'h1;
        for (k = 0; host_int_oe_q !== 1'b1 && k < 1300; k++) step();
        `CHK(k < 1250, 1'b1)
        `CHK({host_int_o_q, int_flag_q[2]}, 2'b01)
        int_clr[2] = 1;
        step();
        int_clr[2] = 0;
        `CHK(int_flag_q, 4'h0)
        step(4);
        `CHK(host_int_oe_q, 1'b0)
        pf_start[1] = 1;
        step();
        pf_start[1] = 0;
        pf_due[1] = 1;
        step();
        pf_due[1] = 0;
        nxt(1);
        `CHK({xfer_src_q[1], xfer_off_q[1]}, {O_PF, 8'h20})
        rem_rw = 0;
        rem(1, 0);
        sw_req[1] = 1;
        step();
        sw_req[1] = 0;
        nxt(1);
        if (xfer_src_q[1] === O_PF) nxt(1);
        `CHK(xfer_src_q[1], O_REM)
        nxt(1);
        `CHK(xfer_src_q[1], O_SW)
        nxt(1);
        `CHK({xfer_src_q[1], xfer_off_q[1]}, {O_PF, 8'h20})
        pf_stop[1] = 1;
        ip_req[3] = 1;
        step();
        pf_stop[1] = 0;
        ip_req[3] = 0;
        nxt(3);
        rem(3, 0);
        `CHK(rem_pend_q[3], 1'b1)
        nxt(3);
        nxt(3);
        `CHK(xfer_src_q[3], O_IP)
        nxt(3);
        `CHK({xfer_src_q[3], rem_pend_q[3]}, {O_REM, 1'b0})
        `CHK({host_int_oe_q, int_flag_q[3]}, 2'b11)
        hold[0] = 1;
        step(190);
        `CHK(scl_stuck_q[0], 1'b0)
        step(20);
        `CHK({scl_stuck_q[0], int_flag_q[0]}, 2'b11)
        hold[0] = 0;
        step(4);
        port_rst[0] = 1;
        step();
        port_rst[0] = 0;
        step(2);
        `CHK(scl_stuck_q[0], 1'b0)
        wrap_up();
    end
endmodule
